/* common/iack_consts.svh */
/*
 * Constants of the interrupt acknowledge and arbitration link: field
 * positions, reset values, encodings and timing counts.
 * Assumes inclusion by bare name from the package and both ends.
 */
`ifndef IACK_CONSTS_SVH
`define IACK_CONSTS_SVH

// Acknowledge cycle encodings
`define IACK_FC_CPU_SPACE 3'h7
`define IACK_ADDR_TYPE_IACK 4'hf
`define IACK_ADDR_HIGH_ONES 4'hf
`define IACK_ADDR_MID_ONES 12'hfff
`define IACK_ADDR_BIT0 1'h1
`define IACK_SIZ_BYTE 2'h1
`define IACK_RW_READ 1'h1

// Arbitration field values
`define IACK_ARB_SIU_RESET 4'hf
`define IACK_ARB_MOD_RESET 4'h0
`define IACK_ARB_NONE 4'h0
`define IACK_ARB_LAST_ROUND 2'h3

// Vector numbers made by the processor itself
`define IACK_VEC_SPURIOUS 8'h0f
`define IACK_VEC_AUTO_BASE 8'h18

// Outcome codes
`define IACK_KIND_VECTOR 2'h0
`define IACK_KIND_AUTO 2'h1
`define IACK_KIND_SPURIOUS 2'h2

// Chip-select answer modes for an external acknowledge
`define IACK_CS_OFF 2'h0
`define IACK_CS_STROBE 2'h1
`define IACK_CS_AUTO 2'h2

// Register map of the controller, byte addresses
`define IACK_REG_CONFIG 4'h0
`define IACK_REG_STATUS 4'h4

// Config register fields
`define IACK_CFG_ARB_LSB 0
`define IACK_CFG_MONEN_BIT 4
`define IACK_CFG_CS_LSB 5
`define IACK_CFG_PORT8_BIT 7
`define IACK_CFG_MASK_LSB 8
`define IACK_CFG_MONEN_RESET 1'h1
`define IACK_MASK_RESET 3'h7

// Status register fields
`define IACK_STS_VEC_LSB 0
`define IACK_STS_LVL_LSB 8
`define IACK_STS_KIND_LSB 11
`define IACK_STS_BUSY_BIT 13

// Bus monitor: 64 cycles at 4 ns is 256 ns
`define IACK_MON_CYCLES 8'h40

`endif

/* common/iack_pkg.sv */
/*
 * Types and shared functions of the interrupt acknowledge link.
 * Assumes iack_consts.svh is on the include path.
 */
`include "iack_consts.svh"

package iack_pkg;

	typedef enum logic [2:0] {D_IDLE, D_START, D_ARB, D_RESP, D_END} iack_dstate_t;
	typedef enum logic [1:0] {R_IDLE, R_ARB, R_ANS} iack_rstate_t;

	typedef struct packed {
		iack_dstate_t st;
		logic [3:0] siuArb;
		logic monEn;
		logic [1:0] csMode;
		logic csPort8;
		logic [2:0] mask;
		logic [2:0] lvl;
		logic [23:0] addr;
		logic [2:0] fc;
		logic [1:0] siz;
		logic rdWr;
		logic ackCycle;
		logic ackStart;
		logic arbValid;
		logic [1:0] round;
		logic arbBit;
		logic arbOe;
		logic siuIn;
		logic siuWon;
		logic anyLine;
		logic bus_error_signal;
		logic [7:0] mon;
		logic extCycle;
		logic extStrobe;
		logic [7:0] vector;
		logic [1:0] kind;
		logic done;
		logic [31:0] rdData;
	} iack_dev_t;

	typedef struct packed {
		iack_rstate_t st;
		logic [2:0] levelOut;
		logic inArb;
		logic arbBit;
		logic arbOe;
		logic data_size_acknowledge;
		logic autovector_request;
		logic [7:0] vecData;
		logic served;
	} iack_req_t;

	// A contender stays in while its bit is one or the line is idle
	function automatic logic keep_in(input logic myBit, input logic line);
		return myBit | ~line;
	endfunction

	// Bit of the arbitration field driven in a round, MSB first
	function automatic logic arb_bit(input logic [3:0] field, input logic [1:0] round);
		return field[2'h3 - round];
	endfunction

	function automatic logic [23:0] ack_addr(input logic [2:0] level);
		return {`IACK_ADDR_HIGH_ONES, `IACK_ADDR_TYPE_IACK, `IACK_ADDR_MID_ONES, level, `IACK_ADDR_BIT0};
	endfunction

endpackage

/* common/iack_if.sv */
/*
 * Interrupt acknowledge link between the processor side and a requesting
 * module. The serial contention line is a wired OR of both drivers.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps

interface iack_if;
	// Processor side
	logic [23:0] addr;
	logic [2:0] fc;
	logic [1:0] siz;
	logic rdWr;
	logic ackCycle;
	logic ackStart;
	logic arbValid;
	logic [1:0] arbRound;
	logic devArbBit;
	logic devArbOe;
	logic bus_error_signal;
	// Requester side
	logic [2:0] reqLevel;
	logic reqArbBit;
	logic reqArbOe;
	logic [7:0] vecData;
	logic data_size_acknowledge;
	logic autovector_request;
	// Resolved contention line
	logic arbLine;

	assign arbLine = (devArbOe & devArbBit) | (reqArbOe & reqArbBit);

	modport dev (
		output addr, fc, siz, rdWr, ackCycle, ackStart, arbValid, arbRound, devArbBit, devArbOe, bus_error_signal,
		input reqLevel, vecData, data_size_acknowledge, autovector_request, arbLine
	);

	modport req (
		input addr, fc, siz, rdWr, ackCycle, ackStart, arbValid, arbRound, bus_error_signal, arbLine,
		output reqLevel, reqArbBit, reqArbOe, vecData, data_size_acknowledge, autovector_request
	);
endinterface

/* rtl/iack_requester.sv */
/*
 * Requesting module end: presents a request level, joins contention when
 * the acknowledged level matches, and answers with a vector or autovector.
 * Assumes the processor end drives the acknowledge cycle on iack_if.
 */
`timescale 1ns/1ps
`include "iack_consts.svh"

module iack_requester (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Link
	iack_if.req bus,
	// Module side
	input wire logic [2:0] reqLevel,
	input wire logic [3:0] arbField,
	input wire logic [7:0] vector,
	input wire logic useAvec,
	output logic served
);
	iack_pkg::iack_req_t s_ff, nxt_s;
	logic keep;

	always_comb begin
		nxt_s = s_ff;
		keep = s_ff.inArb & iack_pkg::keep_in(s_ff.arbBit, bus.arbLine);
		nxt_s.served = 1'h0;
		nxt_s.levelOut = reqLevel;
		case (s_ff.st)
			iack_pkg::R_IDLE: begin
				if (bus.ackStart && bus.fc == `IACK_FC_CPU_SPACE && s_ff.levelOut != 3'h0 &&
					bus.addr[3:1] == s_ff.levelOut) begin
					nxt_s.st = iack_pkg::R_ARB;
					nxt_s.inArb = 1'h1;
					nxt_s.arbBit = iack_pkg::arb_bit(arbField, 2'h0);
					nxt_s.arbOe = 1'h1;
				end
			end
			iack_pkg::R_ARB: begin
				nxt_s.inArb = keep;
				nxt_s.arbOe = keep;
				nxt_s.arbBit = iack_pkg::arb_bit(arbField, bus.arbRound + 2'h1);
				if (!bus.arbValid || bus.arbRound == `IACK_ARB_LAST_ROUND) begin
					nxt_s.inArb = 1'h0;
					nxt_s.arbOe = 1'h0;
					nxt_s.arbBit = 1'h0;
					nxt_s.st = iack_pkg::R_IDLE;
					if (bus.arbValid && keep && arbField != `IACK_ARB_NONE) begin
						nxt_s.st = iack_pkg::R_ANS;
						nxt_s.autovector_request = useAvec;
						nxt_s.data_size_acknowledge = ~useAvec;
						nxt_s.vecData = vector;
					end
				end
			end
			iack_pkg::R_ANS: begin
				if (!bus.ackCycle) begin
					nxt_s.st = iack_pkg::R_IDLE;
					nxt_s.data_size_acknowledge = 1'h0;
					nxt_s.autovector_request = 1'h0;
					nxt_s.served = ~bus.bus_error_signal;
				end
			end
			default: nxt_s.st = iack_pkg::R_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign bus.reqLevel = s_ff.levelOut;
	assign bus.reqArbBit = s_ff.arbBit;
	assign bus.reqArbOe = s_ff.arbOe;
	assign bus.vecData = s_ff.vecData;
	assign bus.data_size_acknowledge = s_ff.data_size_acknowledge;
	assign bus.autovector_request = s_ff.autovector_request;
	assign served = s_ff.served;
endmodule

/* rtl/iack_controller.sv */
/*
 * Processor-side interrupt acknowledge controller: recognises a request
 * above the mask, runs the acknowledge cycle, contends on behalf of the
 * external pins and collects the vector, autovector or bus error.
 * Assumes a requesting module on iack_if and software on the register port.
 */
`timescale 1ns/1ps
`include "iack_consts.svh"

// Behaviour
// - Request above mask starts acknowledge read
// - Acknowledged level copied into mask
// - Requesters join only on level match
// - Serial contention on 4-bit fields
// - Zero field gives spurious interrupt
// - Reset fields: unit 1111, modules 0000
// - Unit field stands for external pins
// - Software avoids duplicate level and field
// - Always contend; external only if unit wins (unit here contends only when the external pins request the acknowledged level)
// - No contender ends cycle with bus error
// - Winner drives vector, ends with acknowledge
// - Function code lines carry CPU space
// - Address 19:16 marks interrupt acknowledge
// - Address 3:1 level, other bits one
// - Size and direction show byte read
// - Responders decode level and size lines (requester here decodes function code and level, not size)
// - Bus monitor timeout gives spurious vector
// - Chip select strobe or internal autovector
// - Vector in low byte of port
// - Autovector answer without data acknowledge
// - Held autovector gives autovector always (pin here heeded only with chip select off)
// - Autovector made from level, data ignored
module iack_controller (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Link
	iack_if.dev bus,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	// External bus pins
	input wire logic [2:0] extReqLevel,
	input wire logic extDsack8,
	input wire logic extDsack16,
	input wire logic extAvec,
	input wire logic [15:0] extData,
	output logic extCycle,
	output logic extIackStrobe,
	// Processor core
	input wire logic boundary,
	output logic ackDone,
	output logic [7:0] ackVector,
	output logic [1:0] ackKind,
	output logic [2:0] maskLevel
);
	iack_pkg::iack_dev_t s_ff, nxt_s;
	logic [2:0] pending;
	logic line;
	logic siuKeep;
	logic answered;

	// Close the cycle with an outcome and drop the cycle at once; the end state only returns to idle
	function automatic iack_pkg::iack_dev_t finish(input iack_pkg::iack_dev_t cur, input logic [7:0] vec,
		input logic [1:0] kind);
		iack_pkg::iack_dev_t r;
		r = cur;
		r.vector = vec;
		r.kind = kind;
		r.st = iack_pkg::D_END;
		r.ackCycle = 1'h0;
		r.extCycle = 1'h0;
		r.extStrobe = 1'h0;
		r.done = 1'h1;
		return r;
	endfunction

	always_comb begin
		nxt_s = s_ff;
		pending = (extReqLevel > bus.reqLevel) ? extReqLevel : bus.reqLevel;
		line = bus.arbLine;
		siuKeep = s_ff.siuIn & iack_pkg::keep_in(s_ff.arbBit, line);
		answered = 1'h0;
		nxt_s.done = 1'h0;
		nxt_s.ackStart = 1'h0;
		nxt_s.bus_error_signal = 1'h0;
		nxt_s.rdData = 32'h0;

		if (regRd) begin
			case (regAddr)
				`IACK_REG_CONFIG: begin
					nxt_s.rdData[`IACK_CFG_ARB_LSB +: 4] = s_ff.siuArb;
					nxt_s.rdData[`IACK_CFG_MONEN_BIT] = s_ff.monEn;
					nxt_s.rdData[`IACK_CFG_CS_LSB +: 2] = s_ff.csMode;
					nxt_s.rdData[`IACK_CFG_PORT8_BIT] = s_ff.csPort8;
					nxt_s.rdData[`IACK_CFG_MASK_LSB +: 3] = s_ff.mask;
				end
				`IACK_REG_STATUS: begin
					nxt_s.rdData[`IACK_STS_VEC_LSB +: 8] = s_ff.vector;
					nxt_s.rdData[`IACK_STS_LVL_LSB +: 3] = s_ff.lvl;
					nxt_s.rdData[`IACK_STS_KIND_LSB +: 2] = s_ff.kind;
					nxt_s.rdData[`IACK_STS_BUSY_BIT] = (s_ff.st != iack_pkg::D_IDLE);
				end
				default: nxt_s.rdData = 32'h0;
			endcase
		end
		if (regWr && regAddr == `IACK_REG_CONFIG) begin
			nxt_s.siuArb = regWrData[`IACK_CFG_ARB_LSB +: 4];
			nxt_s.monEn = regWrData[`IACK_CFG_MONEN_BIT];
			nxt_s.csMode = regWrData[`IACK_CFG_CS_LSB +: 2];
			nxt_s.csPort8 = regWrData[`IACK_CFG_PORT8_BIT];
			nxt_s.mask = regWrData[`IACK_CFG_MASK_LSB +: 3];
		end

		case (s_ff.st)
			iack_pkg::D_IDLE: begin
				if (boundary && pending > s_ff.mask) begin
					nxt_s.st = iack_pkg::D_START;
					nxt_s.lvl = pending;
					// mask takes the level, over a same-cycle write
					nxt_s.mask = pending;
					nxt_s.fc = `IACK_FC_CPU_SPACE;
					nxt_s.addr = iack_pkg::ack_addr(pending);
					nxt_s.siz = `IACK_SIZ_BYTE;
					nxt_s.rdWr = `IACK_RW_READ;
					nxt_s.ackCycle = 1'h1;
					nxt_s.ackStart = 1'h1;
				end
			end
			iack_pkg::D_START: begin
				// unit contends for external pins at this level
				nxt_s.st = iack_pkg::D_ARB;
				nxt_s.siuIn = (extReqLevel == s_ff.lvl);
				nxt_s.arbOe = (extReqLevel == s_ff.lvl);
				nxt_s.arbBit = iack_pkg::arb_bit(s_ff.siuArb, 2'h0);
				nxt_s.round = 2'h0;
				nxt_s.arbValid = 1'h1;
				nxt_s.anyLine = 1'h0;
				nxt_s.mon = 8'h0;
			end
			iack_pkg::D_ARB: begin
				// one field bit per round, MSB first
				nxt_s.anyLine = s_ff.anyLine | line;
				nxt_s.siuIn = siuKeep;
				nxt_s.arbOe = siuKeep;
				nxt_s.arbBit = iack_pkg::arb_bit(s_ff.siuArb, s_ff.round + 2'h1);
				nxt_s.round = s_ff.round + 2'h1;
				if (s_ff.round == `IACK_ARB_LAST_ROUND) begin
					nxt_s.arbValid = 1'h0;
					nxt_s.arbOe = 1'h0;
					nxt_s.arbBit = 1'h0;
					nxt_s.round = 2'h0;
					nxt_s.siuWon = siuKeep;
					if (!(s_ff.anyLine | line)) begin
						// only zero fields or nobody: bus error
						nxt_s = finish(nxt_s, `IACK_VEC_SPURIOUS, `IACK_KIND_SPURIOUS);
						nxt_s.bus_error_signal = 1'h1;
					end else begin
						nxt_s.st = iack_pkg::D_RESP;
						// external bus sees the cycle only on a unit win
						nxt_s.extCycle = siuKeep;
						nxt_s.extStrobe = siuKeep && s_ff.csMode == `IACK_CS_STROBE;
					end
				end
			end
			iack_pkg::D_RESP: begin
				nxt_s.mon = s_ff.mon + 8'h1;
				if (s_ff.siuWon) begin
					// internal autovector needs no device reply
					if (s_ff.csMode == `IACK_CS_AUTO || (s_ff.csMode == `IACK_CS_OFF && extAvec)) begin
						nxt_s = finish(nxt_s, `IACK_VEC_AUTO_BASE + {5'h0, s_ff.lvl}, `IACK_KIND_AUTO);
						answered = 1'h1;
					end else if (s_ff.csMode == `IACK_CS_STROBE || extDsack8 || extDsack16) begin
						if ((s_ff.csMode == `IACK_CS_STROBE) ? s_ff.csPort8 : extDsack8) begin
							nxt_s = finish(nxt_s, extData[15:8], `IACK_KIND_VECTOR);
						end else begin
							nxt_s = finish(nxt_s, extData[7:0], `IACK_KIND_VECTOR);
						end
						answered = 1'h1;
					end
				end else if (bus.autovector_request) begin
					nxt_s = finish(nxt_s, `IACK_VEC_AUTO_BASE + {5'h0, s_ff.lvl}, `IACK_KIND_AUTO);
					answered = 1'h1;
				end else if (bus.data_size_acknowledge) begin
					nxt_s = finish(nxt_s, bus.vecData, `IACK_KIND_VECTOR);
					answered = 1'h1;
				end
				if (!answered && s_ff.monEn && s_ff.mon == `IACK_MON_CYCLES - 8'h1) begin
					nxt_s = finish(nxt_s, `IACK_VEC_SPURIOUS, `IACK_KIND_SPURIOUS);
					nxt_s.bus_error_signal = 1'h1;
				end
			end
			iack_pkg::D_END: begin
				nxt_s.st = iack_pkg::D_IDLE;
			end
			default: nxt_s.st = iack_pkg::D_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_ff <= '0;
			s_ff.siuArb <= `IACK_ARB_SIU_RESET;
			s_ff.monEn <= `IACK_CFG_MONEN_RESET;
			s_ff.mask <= `IACK_MASK_RESET;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign bus.addr = s_ff.addr;
	assign bus.fc = s_ff.fc;
	assign bus.siz = s_ff.siz;
	assign bus.rdWr = s_ff.rdWr;
	assign bus.ackCycle = s_ff.ackCycle;
	assign bus.ackStart = s_ff.ackStart;
	assign bus.arbValid = s_ff.arbValid;
	assign bus.arbRound = s_ff.round;
	assign bus.devArbBit = s_ff.arbBit;
	assign bus.devArbOe = s_ff.arbOe;
	assign bus.bus_error_signal = s_ff.bus_error_signal;
	assign regRdData = s_ff.rdData;
	assign extCycle = s_ff.extCycle;
	assign extIackStrobe = s_ff.extStrobe;
	assign ackDone = s_ff.done;
	assign ackVector = s_ff.vector;
	assign ackKind = s_ff.kind;
	assign maskLevel = s_ff.mask;
endmodule

/* tb/iack_monitor.sv */
/*
 * Checker for the acknowledge link between the processor end and a
 * requesting module. Assumes it sits beside the iack_if instance that
 * joins the two ends and sees its signals as plain inputs.
 */
`timescale 1ns/1ps

module iack_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Processor side
	input wire logic [23:0] addr,
	input wire logic [2:0] fc,
	input wire logic [1:0] siz,
	input wire logic rdWr,
	input wire logic ackCycle,
	input wire logic ackStart,
	input wire logic arbValid,
	input wire logic [1:0] arbRound,
	input wire logic bus_error_signal,
	// Requester side
	input wire logic [2:0] reqLevel,
	input wire logic reqArbBit,
	input wire logic reqArbOe,
	input wire logic data_size_acknowledge,
	input wire logic autovector_request,
	input wire logic arbLine
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	a_fc_cpu_space: assert property (ackCycle |-> fc == 3'h7)
		else $error("function code not CPU space");
	a_addr_type: assert property (ackCycle |-> addr[19:16] == 4'hf)
		else $error("address type field wrong");
	a_addr_ones: assert property (ackCycle |-> addr[23:20] == 4'hf && addr[15:4] == 12'hfff && addr[0])
		else $error("unused address bits not set");
	a_byte_read: assert property (ackCycle |-> siz == 2'h1 && rdWr)
		else $error("size or direction wrong");
	a_four_rounds: assert property (ackStart |=> arbValid [*4] ##1 !arbValid)
		else $error("contention not four rounds");
	a_msb_first: assert property ($rose(arbValid) |->
		arbRound == 2'h0 ##1 arbRound == 2'h1 ##1 arbRound == 2'h2 ##1 arbRound == 2'h3)
		else $error("round order wrong");
	a_level_match: assert property (reqArbOe |-> arbValid && reqLevel == addr[3:1])
		else $error("requester contends at wrong level");
	a_loser_drops: assert property (
		arbValid && reqArbOe && !reqArbBit && arbLine && arbRound != 2'h3 |=> !reqArbOe)
		else $error("losing requester kept driving");
	a_idle_bus_error_signal: assert property (ackStart ##1 (!arbLine) [*4] |=> bus_error_signal)
		else $error("no bus error without contender");
	a_answer_once: assert property (autovector_request |-> !data_size_acknowledge)
		else $error("autovector with data acknowledge");

	c_vector: cover property (ackStart ##[5:8] data_size_acknowledge);
	c_auto: cover property (ackStart ##[5:8] autovector_request);
	c_bus_error_signal: cover property (bus_error_signal);
endmodule

/* tb/interrupt_ack_arbitration_test.sv */
/*
 * Self-checking bench: controller and requester joined by iack_if.
 * Assumes the bench drives the register port, the external pins and the
 * requester's module side, all off the clock edge.
 */
`timescale 1ns/1ps

module interrupt_ack_arbitration_test;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0;
	logic regWr = 1'h0;
	logic regRd = 1'h0;
	logic [31:0] regRdData;
	logic [2:0] extReqLevel = 3'h0;
	logic extDsack8 = 1'h0;
	logic extDsack16 = 1'h0;
	logic extAvec = 1'h0;
	logic [15:0] extData = 16'h0;
	logic extCycle;
	logic extIackStrobe;
	logic boundary = 1'h0;
	logic ackDone;
	logic [7:0] ackVector;
	logic [1:0] ackKind;
	logic [2:0] maskLevel;
	logic [2:0] reqLevel = 3'h0;
	logic [3:0] arbField = 4'h0;
	logic [7:0] vector = 8'h0;
	logic useAvec = 1'h0;
	logic served;
	logic uw;
	logic sawStrobe;
	int j;
	int failCount = 0;
	int nCompared = 0;
	// Unit field in the high nibble, module field in the low one
	logic [7:0] pairs [5] = '{8'h87, 8'h78, 8'h56, 8'h65, 8'h0f};
	// Chip-select setting: bit 2 marks an 8-bit port, bits 1:0 the answer mode
	logic [2:0] xCs [6] = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h1, 3'h5};
	// Pins {autovector, 8-bit ack, 16-bit ack}; never autovector with an ack
	logic [2:0] xAck [6] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h0, 3'h0};
	logic [7:0] xVec [6] = '{8'h1a, 8'h12, 8'ha5, 8'h1a, 8'ha5, 8'h12};
	logic [1:0] xKind [6] = '{2'h1, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0};

	always #2 clk = ~clk;

	iack_if link ();
	iack_controller iack_controller_i (.clk, .reset, .bus(link.dev), .regAddr, .regWrData, .regWr, .regRd,
		.regRdData, .extReqLevel, .extDsack8, .extDsack16, .extAvec, .extData, .extCycle, .extIackStrobe,
		.boundary, .ackDone, .ackVector, .ackKind, .maskLevel);
	iack_requester iack_requester_i (.clk, .reset, .bus(link.req), .reqLevel, .arbField, .vector, .useAvec,
		.served);
	iack_monitor iack_monitor_i (.clk(clk), .reset(reset), .addr(link.addr), .fc(link.fc), .siz(link.siz),
		.rdWr(link.rdWr), .ackCycle(link.ackCycle), .ackStart(link.ackStart), .arbValid(link.arbValid),
		.arbRound(link.arbRound), .bus_error_signal(link.bus_error_signal), .reqLevel(link.reqLevel), .reqArbBit(link.reqArbBit),
		.reqArbOe(link.reqArbOe), .data_size_acknowledge(link.data_size_acknowledge), .autovector_request(link.autovector_request), .arbLine(link.arbLine));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			failCount++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic results();
		$display("Compared %0d, mismatches %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'h1;
		@(posedge clk);
		regWr <= 1'h0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string name);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge clk);
		regRd <= 1'h0;
		#1;
		check(name, regRdData, exp);
	endtask

	task automatic cfg(input logic [3:0] arb, input logic [2:0] cs, input logic [2:0] mask);
		wr(4'h0, {21'h0, mask, cs, 1'h1, arb});
	endtask

	task automatic drive(input logic [2:0] rl, input logic [3:0] af, input logic av, input logic [2:0] el,
		input logic [2:0] ea, input logic [15:0] d);
		@(posedge clk);
		reqLevel <= rl;
		arbField <= af;
		vector <= {af, 4'h9};
		useAvec <= av;
		extReqLevel <= el;
		{extAvec, extDsack8, extDsack16} <= ea;
		extData <= d;
	endtask

	// Kind 3 means no acknowledge may complete within the wait
	task automatic ack(input logic [7:0] ev, input logic [1:0] ek, input logic ex, input logic [2:0] em,
		input string name);
		logic ext;
		int i;
		ext = 1'h0;
		sawStrobe = 1'h0;
		@(posedge clk);
		boundary <= 1'h1;
		@(posedge clk);
		boundary <= 1'h0;
		for (i = 0; i < 120 && ackDone !== 1'h1; i++) begin
			@(posedge clk);
			#1;
			ext |= extCycle;
			sawStrobe |= extIackStrobe;
		end
		if (ek == 2'h3) begin
			check({name, " done"}, ackDone, 32'h0);
			check({name, " mask"}, maskLevel, em);
		end else if (ackDone !== 1'h1) begin
			failCount++;
			$display("[ERR] %s expected done seen none", name);
			results();
		end else begin
			check({name, " vector"}, ackVector, ev);
			check({name, " kind"}, ackKind, ek);
			check({name, " external"}, ext, ex);
			check({name, " mask"}, maskLevel, em);
			// Only a module answer that closes without bus error counts as served
			@(posedge clk);
			#1;
			check({name, " served"}, served, !ex && ek != 2'h2);
		end
	endtask

	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'h0;
		rd(4'h0, 32'h71f, "config");
		check("reset mask", maskLevel, 32'h7);
		rd(4'h8, 32'h0, "unmapped");
		wr(4'h4, 32'hffffffff);
		rd(4'h4, 32'h0, "status");
		drive(3'h5, 4'h3, 1'h0, 3'h0, 3'h0, 16'h0);
		cfg(4'hf, 2'h0, 3'h5);
		ack(8'h0, 2'h3, 1'h0, 3'h5, "masked");
		cfg(4'hf, 2'h0, 3'h4);
		ack(8'h39, 2'h0, 1'h0, 3'h5, "module");
		rd(4'h0, 32'h51f, "config mask");
		rd(4'h4, 32'h539, "status outcome");
		for (j = 0; j < 5; j++) begin
			drive(3'h3, pairs[j][3:0], 1'h0, 3'h3, 3'h0, 16'h0);
			cfg(pairs[j][7:4], 2'h2, 3'h0);
			uw = pairs[j][7:4] > pairs[j][3:0];
			ack(uw ? 8'h1b : {pairs[j][3:0], 4'h9}, uw ? 2'h1 : 2'h0, uw, 3'h3, "contention");
			check("contention strobe", sawStrobe, 32'h0);
		end
		drive(3'h6, 4'h1, 1'h1, 3'h0, 3'h0, 16'h0);
		cfg(4'hf, 2'h0, 3'h0);
		ack(8'h1e, 2'h1, 1'h0, 3'h6, "module auto");
		drive(3'h7, 4'h0, 1'h0, 3'h0, 3'h0, 16'h0);
		ack(8'h0f, 2'h2, 1'h0, 3'h7, "zero field");
		for (j = 0; j < 6; j++) begin
			drive(3'h0, 4'h0, 1'h0, 3'h2, xAck[j], 16'h12a5);
			cfg(4'hf, xCs[j], 3'h0);
			ack(xVec[j], xKind[j], 1'h1, 3'h2, "external");
			check("external strobe", sawStrobe, xCs[j][1:0] == 2'h1);
		end
		drive(3'h0, 4'h0, 1'h0, 3'h4, 3'h0, 16'h0);
		cfg(4'hf, 2'h0, 3'h0);
		ack(8'h0f, 2'h2, 1'h1, 3'h4, "timeout");
		// Monitor off: an unanswered cycle must stay open
		wr(4'h0, 32'hf);
		ack(8'h0, 2'h3, 1'h1, 3'h4, "monitor off");
		results();
	end
endmodule
